// ### inc/wrc_pkg.sv
/*
 * types of the wake rate configuration block.
 * assumes wrc_regs.svh is on the include path.
 */
package wrc_pkg;
    typedef enum logic [2:0] {
        WRC_SEL_NORMAL = 3'h0,
        WRC_SEL_BIAS = 3'h1,
        WRC_SEL_WPICK = 3'h2,
        WRC_SEL_SPICK = 3'h3,
        WRC_SEL_WCNT_LO = 3'h4,
        WRC_SEL_WCNT_HI = 3'h5,
        WRC_SEL_SCNT_LO = 3'h6,
        WRC_SEL_SCNT_HI = 3'h7
    } wrc_sel_e;
    typedef enum logic [1:0] {
        WRC_PM_ULTRA = 2'h0,
        WRC_PM_LOW = 2'h1,
        WRC_PM_PRECISE = 2'h3,
        WRC_PM_OTHER = 2'h2
    } wrc_pmode_e;
endpackage

// ### inc/wrc_regs.svh
/*
 * constants of the wake rate configuration block: register offsets, field
 * positions, reset values and rate codes.
 * assumes it is included by bare name from the bench and the design.
 */
`ifndef WRC_REGS_SVH
`define WRC_REGS_SVH
`define WRC_ADDR_RATE 8'h11
`define WRC_ADDR_SHADOW 8'h29
`define WRC_ADDR_PMODE 8'h1c
`define WRC_RATE_RST 8'h00
`define WRC_RATE_LSB 0
`define WRC_RATE_MSB 3
`define WRC_SEL_LSB 4
`define WRC_SEL_MSB 6
`define WRC_RESERVED_BIT_BIT 7
`define WRC_PM_ULP 3'h3
`define WRC_PM_LP 3'h0
`define WRC_PM_PREC 3'h4
`define WRC_PM_LSB 4
`define WRC_PM_MSB 6
`define WRC_CODE_SW 4'hf
`define WRC_TRIG_RST 8'h00
`define WRC_TUNE_RST 8'h00
`endif

// ### tb/tb_wrc_wake_rate_config.sv
/* self-checking bench of the wake rate block with a host model.
   assumes the design package and register header are compiled first. */
`include "wrc_regs.svh"
module tb_wrc_wake_rate_config;
    import wrc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0, rst_n_i = 1'b0, ce_i = 1'b1, reg_wr_i, rate_valid_o, sw_rate_o;
    logic trig_continuous_o;
    logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, pmode_reg_i = 8'h00, trigger_sample_count_o;
    logic [3:0] output_data_rate_o, sniff_bias_tuning_nibble_o, wake_bias_tuning_nibble_o;
    logic [2:0] manual_shadow_select_o, pm;
    logic [4:0] wake_frequency_pick_o, sniff_frequency_pick_o;
    logic [15:0] wake_clk_count_o, sniff_clk_count_o;
    logic [7:0] tun [8];
    logic [7:0] d, trig;
    logic [16:0] q_a [$];
    logic [16:0] q_b [$];
    int n_errors = 0, comparisons = 0, seed = 28;
    event ev_a, ev_b;
    always #10 clk_i = ~clk_i;
    wrc_host_model host_u (.clk_i(clk_i), .reg_addr_o(reg_addr_i), .reg_wr_o(reg_wr_i),
        .reg_wdata_o(reg_wdata_i));
    wrc_wake_rate_config dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
        .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i),
        .reg_rdata_o(reg_rdata_o), .pmode_reg_i(pmode_reg_i),
        .output_data_rate_o(output_data_rate_o), .rate_valid_o(rate_valid_o),
        .sw_rate_o(sw_rate_o), .manual_shadow_select_o(manual_shadow_select_o),
        .sniff_bias_tuning_nibble_o(sniff_bias_tuning_nibble_o),
        .wake_bias_tuning_nibble_o(wake_bias_tuning_nibble_o),
        .wake_frequency_pick_o(wake_frequency_pick_o),
        .sniff_frequency_pick_o(sniff_frequency_pick_o), .wake_clk_count_o(wake_clk_count_o),
        .sniff_clk_count_o(sniff_clk_count_o), .trigger_sample_count_o(trigger_sample_count_o),
        .trig_continuous_o(trig_continuous_o));
    // tuning entry as seen on the outputs, indexed by select code
    always_comb begin
        tun = '{trigger_sample_count_o, {sniff_bias_tuning_nibble_o, wake_bias_tuning_nibble_o},
            {3'h0, wake_frequency_pick_o}, {3'h0, sniff_frequency_pick_o},
            wake_clk_count_o[7:0], wake_clk_count_o[15:8], sniff_clk_count_o[7:0],
            sniff_clk_count_o[15:8]};
    end
    function automatic logic vld(input logic [2:0] p, input logic [3:0] c);
        if (c == `WRC_CODE_SW) return 1'b1;
        case (p)
            `WRC_PM_ULP: return c >= 4'h6 && c <= 4'hc;
            `WRC_PM_LP: return c >= 4'h5 && c <= 4'hb;
            `WRC_PM_PREC: return c >= 4'h5 && c <= 4'h8;
            default: return 1'b0;
        endcase
    endfunction
    task automatic cmp(input logic [16:0] got, input logic [16:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    initial forever begin
        @(ev_a);
        cmp({rate_valid_o, sw_rate_o, manual_shadow_select_o, output_data_rate_o, reg_rdata_o},
            q_a.pop_front());
    end
    initial forever begin
        @(ev_b);
        cmp({trig_continuous_o, reg_rdata_o, tun[manual_shadow_select_o]}, q_b.pop_front());
    end
    task automatic give_verdict();
        $display("comparisons %0d errors %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        repeat (4000) @(posedge clk_i);
        n_errors++;
        give_verdict();
    end
    initial begin
        repeat (20) @(posedge clk_i);
        #1 rst_n_i = 1'b1;
        host_u.acc(`WRC_ADDR_RATE, 1'b0, 8'h00);
        q_a.push_back(17'h0);
        ->ev_a;
        for (int i = 0; i < 64; i++) begin
            pm = (i < 16) ? `WRC_PM_ULP : (i < 32) ? `WRC_PM_LP : (i < 48) ? `WRC_PM_PREC : 3'h1;
            pmode_reg_i = 8'($random(seed)) & 8'h8f | {1'b0, pm, 4'h0};
            d = 8'($random(seed));
            host_u.acc(`WRC_ADDR_RATE, 1'b1, {d[7:4], i[3:0]});
            host_u.acc(`WRC_ADDR_RATE, 1'b0, 8'h00);
            q_a.push_back({vld(pm, i[3:0]), i[3:0] == 4'hf, d[6:4], i[3:0], 1'b0, d[6:4], i[3:0]});
            ->ev_a;
        end
        for (int s = 0; s < 9; s++) begin
            d = (s == 8) ? 8'hff : 8'($random(seed));
            host_u.acc(`WRC_ADDR_RATE, 1'b1, {1'b0, s[2:0], 4'h6});
            host_u.acc(`WRC_ADDR_SHADOW, 1'b1, d);
            if (s[2:0] == 3'h0) trig = d;
            if (s[2:1] == 2'h1) d = d & 8'h1f;
            host_u.acc(`WRC_ADDR_SHADOW, 1'b0, 8'h00);
            q_b.push_back({trig == 8'hff, d, d});
            ->ev_b;
        end
        host_u.acc(8'h12, 1'b1, 8'hff);
        host_u.acc(8'h12, 1'b0, 8'h00);
        q_a.push_back({1'b0, 1'b0, 3'h0, 4'h6, 8'h00});
        ->ev_a;
        host_u.acc(`WRC_ADDR_RATE, 1'b0, 8'h00);
        q_a.push_back({1'b0, 1'b0, 3'h0, 4'h6, 8'h06});
        ->ev_a;
        // a write with the enable low must be lost
        ce_i = 1'b0;
        host_u.acc(`WRC_ADDR_RATE, 1'b1, 8'h4f);
        ce_i = 1'b1;
        host_u.acc(`WRC_ADDR_RATE, 1'b0, 8'h00);
        q_a.push_back({1'b0, 1'b0, 3'h0, 4'h6, 8'h06});
        ->ev_a;
        // reset in mid-run clears the rate register again
        rst_n_i = 1'b0;
        @(posedge clk_i);
        #1 rst_n_i = 1'b1;
        host_u.acc(`WRC_ADDR_RATE, 1'b0, 8'h00);
        q_a.push_back(17'h0);
        ->ev_a;
        #2 give_verdict();
    end
endmodule

// ### tb/wrc_host_model.sv
/* host side register master for the wake rate block.
   assumes clk_i comes from the bench; drives 1 ns after rising edges. */
module wrc_host_model (
    // clock
    input wire logic clk_i,
    // register port
    output logic [7:0] reg_addr_o,
    output logic reg_wr_o,
    output logic [7:0] reg_wdata_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        reg_addr_o = 8'h00;
        reg_wr_o = 1'b0;
        reg_wdata_o = 8'h00;
    end
    // request held through the taking edge; data then flipped so no stale value lingers
    task automatic acc(input logic [7:0] a, input logic w, input logic [7:0] d);
        @(posedge clk_i);
        #1;
        reg_addr_o = a;
        reg_wr_o = w;
        reg_wdata_o = d;
        @(posedge clk_i);
        #1;
        reg_wr_o = 1'b0;
        reg_wdata_o = ~d;
    endtask
endmodule

// ### verilog/wrc_wake_rate_config.sv
/*
 * wake rate configuration register with the manual shadow select that steers
 * the shared shadow address onto the trigger count and seven hidden rate-tuning registers.
 * assumes a register port (address, write strobe, write data, read data)
 * driven by the serial interface logic, synchronous to clk_i.
 */
`include "wrc_regs.svh"
module wrc_wake_rate_config
    import wrc_pkg::*;
(
    // clock, reset, enable
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    // register port
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    // power mode field from the mode register
    input wire logic [7:0] pmode_reg_i,
    // decoded rate outputs
    output logic [3:0] output_data_rate_o,
    output logic rate_valid_o,
    output logic sw_rate_o,
    output logic [2:0] manual_shadow_select_o,
    // tuning values to the rate generator
    output logic [3:0] sniff_bias_tuning_nibble_o,
    output logic [3:0] wake_bias_tuning_nibble_o,
    output logic [4:0] wake_frequency_pick_o,
    output logic [4:0] sniff_frequency_pick_o,
    output logic [15:0] wake_clk_count_o,
    output logic [15:0] sniff_clk_count_o,
    output logic [7:0] trigger_sample_count_o,
    output logic trig_continuous_o
);
    // ************************************************************
    // decoding
    // ************************************************************
    logic [7:0] rate_q;
    logic [7:0] shadow_q [8];
    logic [3:0] code;
    logic [2:0] pm_field;
    wrc_pmode_e pmode;
    logic valid_d;
    logic wr_rate;
    logic wr_shadow;
    logic [7:0] rdata_d;

    assign code = rate_q[`WRC_RATE_MSB:`WRC_RATE_LSB];
    assign pm_field = pmode_reg_i[`WRC_PM_MSB:`WRC_PM_LSB];
    assign pmode = (pm_field == `WRC_PM_ULP) ? WRC_PM_ULTRA :
                   (pm_field == `WRC_PM_LP) ? WRC_PM_LOW :
                   (pm_field == `WRC_PM_PREC) ? WRC_PM_PRECISE : WRC_PM_OTHER;
    // code 15 is valid in every mode, whether or not tuning is loaded by the host
    assign valid_d = (code == `WRC_CODE_SW) ||
                     (pmode == WRC_PM_ULTRA && code >= 4'h6 && code <= 4'hc) ||
                     (pmode == WRC_PM_LOW && code >= 4'h5 && code <= 4'hb) ||
                     (pmode == WRC_PM_PRECISE && code >= 4'h5 && code <= 4'h8);
    assign wr_rate = ce_i && reg_wr_i && (reg_addr_i == `WRC_ADDR_RATE);
    assign wr_shadow = ce_i && reg_wr_i && (reg_addr_i == `WRC_ADDR_SHADOW);
    // reserved bit reads zero; shadow index is the select field
    assign rdata_d = (reg_addr_i == `WRC_ADDR_RATE) ? {1'b0, rate_q[6:0]} :
                     (reg_addr_i == `WRC_ADDR_SHADOW) ?
                         shadow_q[rate_q[`WRC_SEL_MSB:`WRC_SEL_LSB]] : 8'h00;

    // ************************************************************
    // registers
    // ************************************************************
    // bit 7 never stored
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            rate_q <= `WRC_RATE_RST;
        end else if (wr_rate) begin
            rate_q <= {1'b0, reg_wdata_i[6:0]};
        end
    end

    // entry 0 is the trigger count, 1..7 the hidden tuning registers
    genvar gi;
    for (gi = 0; gi < 8; gi++) begin : g_shadow
        always_ff @(posedge clk_i) begin
            if (!rst_n_i) begin
                shadow_q[gi] <= (gi == 0) ? `WRC_TRIG_RST : `WRC_TUNE_RST;
            end else if (wr_shadow && rate_q[`WRC_SEL_MSB:`WRC_SEL_LSB] == 3'(gi)) begin
                // pick entries keep only 5 bits so the pad reads zero
                shadow_q[gi] <= (gi == 2 || gi == 3) ? {3'h0, reg_wdata_i[4:0]} : reg_wdata_i;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            reg_rdata_o <= 8'h00;
            output_data_rate_o <= 4'h0;
            rate_valid_o <= 1'b0;
            sw_rate_o <= 1'b0;
            manual_shadow_select_o <= 3'h0;
            sniff_bias_tuning_nibble_o <= 4'h0;
            wake_bias_tuning_nibble_o <= 4'h0;
            wake_frequency_pick_o <= 5'h00;
            sniff_frequency_pick_o <= 5'h00;
            wake_clk_count_o <= 16'h0000;
            sniff_clk_count_o <= 16'h0000;
            trigger_sample_count_o <= 8'h00;
            trig_continuous_o <= 1'b0;
        end else if (ce_i) begin
            reg_rdata_o <= rdata_d;
            output_data_rate_o <= code;
            rate_valid_o <= valid_d;
            sw_rate_o <= (code == `WRC_CODE_SW);
            manual_shadow_select_o <= rate_q[`WRC_SEL_MSB:`WRC_SEL_LSB];
            sniff_bias_tuning_nibble_o <= shadow_q[WRC_SEL_BIAS][7:4];
            wake_bias_tuning_nibble_o <= shadow_q[WRC_SEL_BIAS][3:0];
            wake_frequency_pick_o <= shadow_q[WRC_SEL_WPICK][4:0];
            sniff_frequency_pick_o <= shadow_q[WRC_SEL_SPICK][4:0];
            wake_clk_count_o <= {shadow_q[WRC_SEL_WCNT_HI], shadow_q[WRC_SEL_WCNT_LO]};
            sniff_clk_count_o <= {shadow_q[WRC_SEL_SCNT_HI], shadow_q[WRC_SEL_SCNT_LO]};
            trigger_sample_count_o <= shadow_q[WRC_SEL_NORMAL];
            trig_continuous_o <= (shadow_q[WRC_SEL_NORMAL] == 8'hff);
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    reset_zero_a: assert property (@(posedge clk_i)
        !rst_n_i |=> rate_q == 8'h00) else $error("rate register not zero after reset");
    reserved_bit_zero_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ce_i && reg_addr_i == `WRC_ADDR_RATE |=> !reg_rdata_o[7])
        else $error("reserved bit read back as one");
    rate_write_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        wr_rate |=> rate_q[6:0] == $past(reg_wdata_i[6:0])) else $error("rate write lost");
    ulp_gap_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ce_i && pmode == WRC_PM_ULTRA && code == 4'h5 |=> !rate_valid_o)
        else $error("code 5 accepted in ultra-low power");
    prec_high_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ce_i && pmode == WRC_PM_PRECISE && code == 4'h9 |=> !rate_valid_o)
        else $error("code 9 accepted in precision");
    sw_rate_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ce_i && code == 4'hf |=> sw_rate_o && rate_valid_o) else $error("software rate missed");
    pick_pad_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ce_i && reg_addr_i == `WRC_ADDR_SHADOW && rate_q[6:5] == 2'h1 |=> reg_rdata_o[7:5] == 3'h0)
        else $error("frequency pick pad not zero");
    count_byte_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        wr_shadow && rate_q[6:4] == 3'h5 ##1 ce_i |=>
        wake_clk_count_o[15:8] == $past(reg_wdata_i, 2)) else $error("wake count high byte wrong");
    shadow_read_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ce_i && reg_addr_i == `WRC_ADDR_SHADOW |=> reg_rdata_o == $past(shadow_q[rate_q[6:4]]))
        else $error("shadow read not steered by select");
    trig_cont_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ce_i && shadow_q[0] == 8'hff |=> trig_continuous_o) else $error("continuous not flagged");

    // ************************************************************
    // checks: clock enable and address decode
    // ************************************************************
    // a frozen block must drop any write and hold rate register and read data while the enable is low
    ce_hold_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !ce_i |=> $stable(rate_q) && $stable(reg_rdata_o))
        else $error("state moved with enable low");
    other_write_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ce_i && reg_wr_i && reg_addr_i != `WRC_ADDR_RATE && reg_addr_i != `WRC_ADDR_SHADOW
        |=> $stable(rate_q)) else $error("foreign write changed rate register");
    other_read_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ce_i && reg_addr_i != `WRC_ADDR_RATE && reg_addr_i != `WRC_ADDR_SHADOW
        |=> reg_rdata_o == 8'h00) else $error("foreign address read not zero");

    // ************************************************************
    // checks: rate decode
    // ************************************************************
    rate_code_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ce_i |=> output_data_rate_o == $past(code))
        else $error("rate code output stale");
    ulp_top_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ce_i && pmode == WRC_PM_ULTRA && code == 4'hc |=> rate_valid_o)
        else $error("code 12 refused in ultra-low power");
    lp_low_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ce_i && pmode == WRC_PM_LOW && code == 4'h5 |=> rate_valid_o)
        else $error("code 5 refused in low power");
    lp_map_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ce_i && pm_field == 3'h0 && code == 4'hb |=> rate_valid_o)
        else $error("power mode zero not read as low power");
    other_mode_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ce_i && pmode == WRC_PM_OTHER && code != 4'hf |=> !rate_valid_o)
        else $error("rate accepted without a rate table");
    sw_off_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ce_i && code != 4'hf |=> !sw_rate_o)
        else $error("software rate flagged for a table code");

    // ************************************************************
    // checks: shadow entries
    // ************************************************************
    sel_out_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ce_i |=> manual_shadow_select_o == $past(rate_q[6:4]))
        else $error("select output stale");
    shadow_steer_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        wr_shadow && rate_q[6:4] == 3'h1 |=> $stable(shadow_q[0]))
        else $error("shadow write hit the wrong entry");
    bias_split_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ce_i |=> {sniff_bias_tuning_nibble_o, wake_bias_tuning_nibble_o} == $past(shadow_q[1]))
        else $error("bias nibbles swapped");
    wpick_out_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ce_i |=> wake_frequency_pick_o == $past(shadow_q[2][4:0]))
        else $error("wake pick output wrong");
    spick_out_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ce_i |=> sniff_frequency_pick_o == $past(shadow_q[3][4:0]))
        else $error("sniff pick output wrong");
    pick_store_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        wr_shadow && rate_q[6:4] == 3'h2 |=> shadow_q[2][7:5] == 3'h0)
        else $error("wake pick stored pad bits");
    wcount_lo_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ce_i |=> wake_clk_count_o[7:0] == $past(shadow_q[4]))
        else $error("wake count low byte wrong");
    scount_out_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ce_i |=> sniff_clk_count_o == $past({shadow_q[7], shadow_q[6]}))
        else $error("sniff count bytes wrong");
    trigger_sample_count_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ce_i |=> trigger_sample_count_o == $past(shadow_q[0]))
        else $error("trigger count output wrong");
    // a finite count must never be mistaken for continuous sampling
    trig_finite_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ce_i && shadow_q[0] != 8'hff |=> !trig_continuous_o)
        else $error("finite count flagged continuous");
endmodule
